// ---- rtl/cgir_pkg.sv ----
package cgir_pkg;
  // ----------------------------------------------------------------------------
  // register indexes carried in the command address slot
  // ----------------------------------------------------------------------------
  localparam int             IDX_W          = 7;
  localparam logic [6:0]     IDX_GP         = 7'h20;  // general_purpose_control
  localparam logic [6:0]     IDX_WIDEN      = 7'h22;  // stereo_widening_control
  localparam logic [6:0]     IDX_IRQ        = 7'h24;  // audio_interrupt_and_page

  // ----------------------------------------------------------------------------
  // field positions inside the 16-bit register words
  // ----------------------------------------------------------------------------
  localparam int             GP_BYPASS_BIT  = 15;
  localparam int             GP_WIDEN_BIT   = 13;
  localparam int             GP_MONO_BIT    = 9;
  localparam int             GP_MIC_BIT     = 8;
  localparam int             GP_LOOP_BIT    = 7;
  localparam int             WD_RATIO_LSB   = 2;
  localparam int             IRQ_STAT_BIT   = 15;
  localparam int             IRQ_CAUSE_LSB  = 13;
  localparam int             IRQ_SENSE_BIT  = 12;
  localparam int             IRQ_MASK_BIT   = 11;
  localparam int             PAGE_W         = 4;

  // ----------------------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------------------
  localparam logic [3:0]     PAGE_RST       = 4'h0;   // also the vendor-specific page
  localparam logic [1:0]     CAUSE_NONE     = 2'h0;
  localparam logic [1:0]     CAUSE_SENSE    = 2'h1;
  localparam logic [1:0]     CAUSE_GPIO     = 2'h2;
  localparam logic [1:0]     CAUSE_BOTH     = 2'h3;

  // ----------------------------------------------------------------------------
  // link frame layout, bit index within a 256-bit frame, msb first
  // ----------------------------------------------------------------------------
  localparam logic [7:0]     TAG_LAST       = 8'h0f;
  localparam logic [7:0]     SLOT1_LAST     = 8'h23;
  localparam logic [7:0]     SLOT2_LAST     = 8'h37;
  localparam logic [7:0]     SLOT12_FIRST   = 8'hec;
  localparam logic [7:0]     FRAME_LAST     = 8'hff;
  localparam int             TAG_READY      = 15;
  localparam int             TAG_SLOT1      = 14;
  localparam int             TAG_SLOT2      = 13;
  localparam int             TAG_SLOT12     = 3;
  localparam int             CMD_RW_BIT     = 19;
  localparam int             CMD_IDX_LSB    = 12;
  localparam int             DATA_LSB       = 4;

  // widening depth codes
  typedef enum logic [1:0] {
    CGIR_DEPTH_OFF  = 2'b00,
    CGIR_DEPTH_LOW  = 2'b01,
    CGIR_DEPTH_MED  = 2'b10,
    CGIR_DEPTH_HIGH = 2'b11
  } cgir_depth_t;

  // routing controls handed to the analog side
  typedef struct packed {
    logic        dac_bypass;
    logic        widen_en;
    logic        mono_mic;
    logic        mic_two;
    logic        loopback;
    cgir_depth_t depth;
  } cgir_route_t;
endpackage : cgir_pkg

// ---- rtl/cgir_regs.sv ----
// Overview of operation
// [RULE1] bypass bit sends dac straight to outputs
// [RULE2] widen enable bit turns widening on
// [RULE3] mono out from mix or microphone
// [RULE4] mic select picks input one or two
// [RULE5] loopback bit loops adc into dac
// [RULE6] controller sends no conflicting playback during loopback
// [RULE7] reserved bits always read zero
// [RULE8] separation ratio sets widening depth
// [RULE9] ratio acts only while widening enabled
// [RULE10] status sets on event, write one clears
// [RULE11] status sets regardless of mask
// [RULE12] unmasked status mirrored to slot 12 gpi
// [RULE13] cause codes sense, gpio or both
// [RULE14] cause holds first event while pending
// [RULE15] write one starts sense, reads busy
// [RULE16] mask enable zero masks, one unmasks
// [RULE17] controller unmasks only without slot 12 conflict
// [RULE18] controller polls status after sense delay
// [RULE19] page select picks page for window
// [RULE20] page zero maps vendor space
// [RULE21] pages numbered consecutively from one
// [RULE22] page select survives cold reset
// [RULE23] unimplemented page reads back differently
// [RULE24] read-only and reserved bits ignore writes
`timescale 1ns/1ps
module cgir_regs
  import cgir_pkg::*;
#(
  parameter int          PAGE_COUNT = 1,   // implemented pages 1..PAGE_COUNT
  parameter bit          SENSE_SUP  = 1'b1 // sense cycle supported
) (
  // system clock and power-up reset
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  // link pins
  input  wire logic                 bit_clk,
  input  wire logic                 cold_rst_n,
  input  wire logic                 sync,
  input  wire logic                 sdata_out,
  output logic                      sdata_in,
  // analog side, clk_sys domain
  output cgir_pkg::cgir_route_t     route,
  output logic                      sense_start,
  input  wire logic                 sense_done,
  input  wire logic                 gpio_change,
  // paged window selector, bit_clk domain
  output logic [cgir_pkg::PAGE_W-1:0] window_page
);
  import cgir_pkg::*;

  // ----------------------------------------------------------------------------
  // link-domain resets
  // ----------------------------------------------------------------------------
  logic        por_s1;                     // power-up reset synchroniser
  logic        por_rst;                    // power-up reset, bit_clk release
  logic        link_rst;                   // power-up or cold reset

  // assert with sys_rst at once, release on bit_clk two edges later
  always_ff @(posedge bit_clk or posedge sys_rst) begin
    if (sys_rst) begin
      por_s1  <= 1'b1;
      por_rst <= 1'b1;
    end else begin
      por_s1  <= 1'b0;
      por_rst <= por_s1;
    end
  end

  assign link_rst = por_rst | ~cold_rst_n;

  // ----------------------------------------------------------------------------
  // frame position and input shift
  // ----------------------------------------------------------------------------
  logic        sync_d;                     // previous sync sample
  logic        live;                       // at least one frame seen
  logic [7:0]  pos;                        // index expected at this edge
  logic [7:0]  cur_idx;                    // index of the bit sampled now
  logic [54:0] shreg;                      // bits already shifted in
  logic [55:0] head;                       // tag, command and data slots
  logic        cmd_now;                    // last bit of slot 2 sampled now

  assign cur_idx = (sync && !sync_d) ? 8'h00 : pos;
  assign head    = {shreg, sdata_out};
  assign cmd_now = live && (cur_idx == SLOT2_LAST);

  // a sync rise realigns the count, otherwise it wraps every 256 bits
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      sync_d <= 1'b0;
      live   <= 1'b0;
      pos    <= 8'h00;
      shreg  <= '0;
    end else begin
      sync_d <= sync;
      pos    <= cur_idx + 8'h01;
      shreg  <= head[54:0];
      if (sync && !sync_d)
        live <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------------
  logic        cmd_ok;                     // valid frame with slot 1 tagged
  logic        wr_ok;                      // write with slot 2 tagged
  logic [6:0]  cmd_idx;                    // addressed register index
  logic [15:0] wdata;                      // written data word
  logic        wr_gp;
  logic        wr_wd;
  logic        wr_irq;

  assign cmd_ok  = cmd_now && head[55] && head[55-(15-TAG_SLOT1)];
  assign cmd_idx = head[20+CMD_IDX_LSB +: IDX_W];
  assign wdata   = head[DATA_LSB +: 16];
  assign wr_ok   = cmd_ok && !head[20+CMD_RW_BIT] && head[55-(15-TAG_SLOT2)];
  assign wr_gp   = wr_ok && (cmd_idx == IDX_GP);
  assign wr_wd   = wr_ok && (cmd_idx == IDX_WIDEN);
  assign wr_irq  = wr_ok && (cmd_idx == IDX_IRQ);

  // ----------------------------------------------------------------------------
  // routing registers, cleared by cold reset
  // ----------------------------------------------------------------------------
  cgir_route_t ctrl;                       // link-side copy of the routing bits
  logic        ctrl_tgl;                   // flips after each routing write

  // only the documented fields are stored, reserved data bits are dropped
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      ctrl <= '0;
    end else begin
      if (wr_gp) begin                                              // [RULE24]
        ctrl.dac_bypass <= wdata[GP_BYPASS_BIT];                    // [RULE1]
        ctrl.widen_en   <= wdata[GP_WIDEN_BIT];                     // [RULE2]
        ctrl.mono_mic   <= wdata[GP_MONO_BIT];                      // [RULE3]
        ctrl.mic_two    <= wdata[GP_MIC_BIT];                       // [RULE4]
        ctrl.loopback   <= wdata[GP_LOOP_BIT];                      // [RULE5]
      end
      if (wr_wd)
        ctrl.depth <= cgir_depth_t'(wdata[WD_RATIO_LSB +: 2]);      // [RULE8]
    end
  end

  // the toggle lives on power-up reset only; while cold reset is held it flips on every bit_clk edge so route reloads the cleared ctrl
  always_ff @(posedge bit_clk or posedge por_rst) begin
    if (por_rst)
      ctrl_tgl <= 1'b0;
    else if (wr_gp || wr_wd || !cold_rst_n)
      ctrl_tgl <= ~ctrl_tgl;
  end

  // ----------------------------------------------------------------------------
  // page selector, untouched by cold reset
  // ----------------------------------------------------------------------------
  logic [PAGE_W-1:0] page_req;             // page number being written
  logic              page_impl;            // written page exists

  assign page_req  = wdata[PAGE_W-1:0];
  assign page_impl = (page_req == PAGE_RST) || (32'(page_req) <= PAGE_COUNT);  // [RULE21]

  // missing pages are refused, so read-back differs from the value written
  always_ff @(posedge bit_clk or posedge por_rst) begin
    if (por_rst)
      window_page <= PAGE_RST;                                      // [RULE22]
    else if (wr_irq && page_impl)
      window_page <= page_req;                                      // [RULE19] [RULE20] [RULE23]
  end

  // ----------------------------------------------------------------------------
  // events from the analog side, crossed as toggles
  // ----------------------------------------------------------------------------
  logic        sd_tgl;                     // clk_sys: sense done toggle
  logic        gc_tgl;                     // clk_sys: gpio change toggle
  logic [1:0]  sd_sync;                    // bit_clk synchronisers
  logic [1:0]  gc_sync;
  logic        sd_d;                       // last seen toggle values
  logic        gc_d;
  logic [1:0]  arm;                        // settles synchronisers after reset
  logic        ev_sense;
  logic        ev_gpio;
  logic        any_ev;

  // pulses become toggles so nothing is lost while bit_clk is slow
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      sd_tgl <= 1'b0;
      gc_tgl <= 1'b0;
    end else begin
      sd_tgl <= sd_tgl ^ sense_done;
      gc_tgl <= gc_tgl ^ gpio_change;
    end
  end

  // edges are ignored until the chains hold real samples
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      sd_sync <= 2'h0;
      gc_sync <= 2'h0;
      sd_d    <= 1'b0;
      gc_d    <= 1'b0;
      arm     <= 2'h0;
    end else begin
      sd_sync <= {sd_sync[0], sd_tgl};
      gc_sync <= {gc_sync[0], gc_tgl};
      sd_d    <= sd_sync[1];
      gc_d    <= gc_sync[1];
      if (arm != 2'h3)
        arm <= arm + 2'h1;
    end
  end

  assign ev_sense = (arm == 2'h3) && (sd_sync[1] != sd_d);
  assign ev_gpio  = (arm == 2'h3) && (gc_sync[1] != gc_d);
  assign any_ev   = ev_sense || ev_gpio;

  // ----------------------------------------------------------------------------
  // interrupt status, cause, mask and sense cycle
  // ----------------------------------------------------------------------------
  logic        irq_status;
  logic [1:0]  irq_cause;
  logic        irq_mask_enable;
  logic        sense_busy;                 // reads as sense_cycle_ctl
  logic        irq_clr;
  logic        sense_go;
  logic        start_tgl;                  // flips on each sense start

  assign irq_clr  = wr_irq && wdata[IRQ_STAT_BIT];
  assign sense_go = SENSE_SUP && wr_irq && wdata[IRQ_SENSE_BIT] && !sense_busy;

  // an event in the clearing cycle wins; the mask never gates the flag
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      irq_status <= 1'b0;
      irq_cause  <= CAUSE_NONE;
    end else begin
      if (any_ev)
        irq_status <= 1'b1;                                         // [RULE10] [RULE11]
      else if (irq_clr)
        irq_status <= 1'b0;                                         // [RULE10]
      // only the first event of a pending interrupt names its cause
      if (any_ev && (!irq_status || irq_clr))
        irq_cause <= {ev_gpio, ev_sense};                           // [RULE13] [RULE14]
      else if (irq_clr)
        irq_cause <= CAUSE_NONE;
    end
  end

  // mask bit and sense busy; busy ends with the completion event
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      irq_mask_enable <= 1'b0;
      sense_busy      <= 1'b0;
    end else begin
      if (wr_irq)
        irq_mask_enable <= wdata[IRQ_MASK_BIT];                     // [RULE16]
      // a start beats a stray completion in the same edge, else busy would be lost
      if (sense_go)
        sense_busy <= 1'b1;                                         // [RULE15]
      else if (ev_sense)
        sense_busy <= 1'b0;
    end
  end

  always_ff @(posedge bit_clk or posedge por_rst) begin
    if (por_rst)
      start_tgl <= 1'b0;
    else if (sense_go)
      start_tgl <= ~start_tgl;                                      // [RULE15]
  end

  // ----------------------------------------------------------------------------
  // read response and serial output
  // ----------------------------------------------------------------------------
  logic [15:0] rd_word;                    // register image at the read index
  logic        rd_pend;                    // answer waits for next frame
  logic [6:0]  rd_idx;
  logic [15:0] rd_data;
  logic        tx_valid;                   // answer carried in this frame
  logic [6:0]  tx_idx;
  logic [15:0] tx_data;
  logic        gpi_int;                    // interrupt bit for slot 12
  logic [7:0]  nxt;                        // index driven after this edge
  logic        next_sdata_in;

  // reserved bits are built as zero; unknown indexes answer zero
  always_comb begin
    rd_word = 16'h0000;                                             // [RULE7]
    unique case (cmd_idx)
      IDX_GP: begin
        rd_word[GP_BYPASS_BIT] = ctrl.dac_bypass;
        rd_word[GP_WIDEN_BIT]  = ctrl.widen_en;
        rd_word[GP_MONO_BIT]   = ctrl.mono_mic;
        rd_word[GP_MIC_BIT]    = ctrl.mic_two;
        rd_word[GP_LOOP_BIT]   = ctrl.loopback;
      end
      IDX_WIDEN: rd_word[WD_RATIO_LSB +: 2] = ctrl.depth;
      IDX_IRQ: begin
        rd_word[IRQ_STAT_BIT]         = irq_status;
        rd_word[IRQ_CAUSE_LSB +: 2]   = irq_cause;
        rd_word[IRQ_SENSE_BIT]        = sense_busy;
        rd_word[IRQ_MASK_BIT]         = irq_mask_enable;
        rd_word[PAGE_W-1:0]           = window_page;
      end
      default: rd_word = 16'h0000;
    endcase
  end

  // reads caught at slot 2 end go out in the following frame
  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst) begin
      rd_pend  <= 1'b0;
      rd_idx   <= '0;
      rd_data  <= 16'h0000;
      tx_valid <= 1'b0;
      tx_idx   <= '0;
      tx_data  <= 16'h0000;
      gpi_int  <= 1'b0;
    end else begin
      gpi_int <= irq_status && irq_mask_enable;                     // [RULE12] [RULE16]
      if (cmd_ok && head[20+CMD_RW_BIT]) begin
        rd_pend <= 1'b1;
        rd_idx  <= cmd_idx;
        rd_data <= rd_word;
      end else if (cur_idx == FRAME_LAST) begin
        rd_pend  <= 1'b0;
        tx_valid <= rd_pend;
        tx_idx   <= rd_idx;
        tx_data  <= rd_data;
      end
    end
  end

  assign nxt = cur_idx + 8'h01;

  // pick the bit for the next index, msb of each slot first
  always_comb begin
    next_sdata_in = 1'b0;
    if (nxt <= TAG_LAST)
      next_sdata_in = (4'(TAG_LAST - nxt) == 4'(TAG_READY))
                   || (tx_valid && (4'(TAG_LAST - nxt) == 4'(TAG_SLOT1)))
                   || (tx_valid && (4'(TAG_LAST - nxt) == 4'(TAG_SLOT2)))
                   || (4'(TAG_LAST - nxt) == 4'(TAG_SLOT12));
    else if (nxt <= SLOT1_LAST)
      next_sdata_in = tx_valid && (5'(SLOT1_LAST - nxt) >= 5'(CMD_IDX_LSB))
                   && (5'(SLOT1_LAST - nxt) < 5'(CMD_IDX_LSB + IDX_W))
                   && tx_idx[3'(5'(SLOT1_LAST - nxt) - 5'(CMD_IDX_LSB))];
    else if (nxt <= SLOT2_LAST)
      next_sdata_in = tx_valid && (5'(SLOT2_LAST - nxt) >= 5'(DATA_LSB))
                   && tx_data[4'(5'(SLOT2_LAST - nxt) - 5'(DATA_LSB))];
    else if (nxt == FRAME_LAST)
      next_sdata_in = gpi_int;                                      // [RULE12]
  end

  always_ff @(posedge bit_clk or posedge link_rst) begin
    if (link_rst)
      sdata_in <= 1'b0;
    else
      sdata_in <= live && next_sdata_in;
  end

  // ----------------------------------------------------------------------------
  // clk_sys side: routing capture and sense start
  // ----------------------------------------------------------------------------
  logic [1:0]  crst_sync;                  // cold reset pin synchroniser
  logic [1:0]  ct_sync;                    // routing toggle synchroniser
  logic        ct_d;
  logic [1:0]  st_sync;                    // sense start synchroniser
  logic        st_d;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      crst_sync <= 2'h0;
      ct_sync   <= 2'h0;
      ct_d      <= 1'b0;
      st_sync   <= 2'h0;
      st_d      <= 1'b0;
    end else begin
      crst_sync <= {crst_sync[0], cold_rst_n};
      ct_sync   <= {ct_sync[0], ctrl_tgl};
      ct_d      <= ct_sync[1];
      st_sync   <= {st_sync[0], start_tgl};
      st_d      <= st_sync[1];
    end
  end

  // ctrl is held for a whole frame after its toggle, so the word is stable
  // when the toggle edge arrives here; loopback trusts the controller to
  // keep playback quiet, nothing is blocked on the link
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      route       <= '0;
      sense_start <= 1'b0;
    end else begin
      sense_start <= st_sync[1] ^ st_d;                             // [RULE15]
      if (!crst_sync[1])
        route <= '0;
      else if (ct_sync[1] != ct_d) begin
        route       <= ctrl;                                        // [RULE1] [RULE5] [RULE6]
        route.depth <= ctrl.widen_en ? ctrl.depth : CGIR_DEPTH_OFF; // [RULE9]
      end
    end
  end

  // ----------------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------------
  sequence s_status_clear;
    wr_irq && wdata[IRQ_STAT_BIT] && !any_ev;
  endsequence
  sequence s_sense_begin;
    sense_go ##1 sense_busy;
  endsequence

  chk_route_follow: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE1]
    (crst_sync[1] && ct_sync[1] != ct_d) |=> (route.dac_bypass == $past(ctrl.dac_bypass)
      && route.mono_mic == $past(ctrl.mono_mic) && route.mic_two == $past(ctrl.mic_two)))
    else $error("routing bits not taken from link copy");
  chk_depth_gate: assert property (@(posedge clk_sys) disable iff (sys_rst) // [RULE9]
    !route.widen_en |-> route.depth == CGIR_DEPTH_OFF)
    else $error("depth active while widening off");
  chk_status_set: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE11]
    any_ev |=> irq_status)
    else $error("event did not set status");
  chk_status_clr: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE10]
    s_status_clear |=> !irq_status && irq_cause == CAUSE_NONE)
    else $error("write one did not clear status");
  chk_cause_hold: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE14]
    (irq_status && !irq_clr) |=> $stable(irq_cause))
    else $error("cause replaced while pending");
  chk_cause_code: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE13]
    (any_ev && !irq_status) |=> irq_cause == {$past(ev_gpio), $past(ev_sense)})
    else $error("cause code wrong");
  chk_gpi_mirror: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE12]
    (irq_status && irq_mask_enable) ##1 (irq_status && irq_mask_enable) |-> gpi_int)
    else $error("gpi not following unmasked status");
  chk_sense_busy: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE15]
    sense_go |-> s_sense_begin or (sense_go ##1 $past(ev_sense)))
    else $error("sense cycle not shown busy");
  chk_page_refuse: assert property (@(posedge bit_clk) disable iff (por_rst) // [RULE23]
    (wr_irq && !page_impl) |=> $stable(window_page))
    else $error("unimplemented page stored");
  chk_reserved_zero: assert property (@(posedge bit_clk) disable iff (link_rst) // [RULE7]
    cmd_now |-> (rd_word & ((cmd_idx == IDX_GP) ? 16'h5c7f : (cmd_idx == IDX_WIDEN) ? 16'hfff3
      : (cmd_idx == IDX_IRQ) ? 16'h07f0 : 16'hffff)) == 16'h0000)
    else $error("reserved bits read nonzero");
endmodule : cgir_regs

// ---- verif/cgir_link_ctrl.sv ----
`timescale 1ns/1ps
module cgir_link_ctrl (
  // link pins
  input  wire logic bit_clk,
  input  wire logic sdata_in,
  output logic      sync,
  output logic      sdata_out
);
  logic [255:0] rx;  // last frame heard from the codec
  initial begin
    sync = 1'b0;
    sdata_out = 1'b0;
  end
  // one frame, msb first; never sends playback slots, so loopback sees no clash
  task automatic frame(input logic [255:0] tx);
    for (int j = 0; j <= 256; j++) begin
      @(posedge bit_clk);
      if (j > 0) rx[256-j] = sdata_in;
      sync      <= (j < 16);
      sdata_out <= (j < 256) ? tx[255-j] : 1'b0;
    end
  endtask : frame
endmodule : cgir_link_ctrl

// ---- verif/test_codec_gp_enhance_irq_paging_regs.sv ----
`timescale 1ns/1ps
module test_codec_gp_enhance_irq_paging_regs;
  import cgir_pkg::*;
  logic clk_sys, sys_rst, bit_clk, cold_rst_n, sense_done, gpio_change, sync, sdata_out, sdata_in, sense_start;
  cgir_route_t route;
  logic [3:0]  window_page;
  logic [15:0] rd;  // read answer
  int          bad_count, samples_checked, starts;
  cgir_regs dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .bit_clk(bit_clk), .cold_rst_n(cold_rst_n), .sync(sync),
    .sdata_out(sdata_out), .sdata_in(sdata_in), .route(route), .sense_start(sense_start),
    .sense_done(sense_done), .gpio_change(gpio_change), .window_page(window_page));
  cgir_link_ctrl ctrl (.bit_clk(bit_clk), .sdata_in(sdata_in), .sync(sync), .sdata_out(sdata_out));
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  // link clock, phase unrelated to clk_sys
  initial begin
    bit_clk = 1'b0;
    #7;
    forever #62.5 bit_clk = ~bit_clk;
  end
  always @(posedge clk_sys) if (sense_start === 1'b1) starts++;
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [6:0] idx, input logic [15:0] d);
    ctrl.frame({3'b111, 13'h0, 1'b0, idx, 12'h0, d, 204'h0});
  endtask : wr
  // answer comes in the frame after the command
  task automatic rdr(input logic [6:0] idx);
    ctrl.frame({3'b110, 13'h0, 1'b1, idx, 12'h0, 220'h0});
    ctrl.frame('0);
    rd = ctrl.rx[219:204];
  endtask : rdr
  task automatic pulse(input bit g);
    @(posedge clk_sys);
    if (g) gpio_change <= 1'b1;
    else sense_done <= 1'b1;
    @(posedge clk_sys);
    gpio_change <= 1'b0;
    sense_done <= 1'b0;
    repeat (4) @(posedge bit_clk);
  endtask : pulse
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run
  // hang guard
  initial begin
    #2000000;
    bad_count++;
    complete_run();
  end
  initial begin
    sys_rst = 1'b1;
    cold_rst_n = 1'b1;
    sense_done = 1'b0;
    gpio_change = 1'b0;
    repeat (10) @(posedge clk_sys);  // long enough for the link side too
    sys_rst <= 1'b0;
    repeat (6) @(posedge bit_clk);
    wr(IDX_GP, 16'hffff);
    rdr(IDX_GP);
    chk(rd, 16'ha380);
    chk({11'h0, route[6:2]}, 16'h001f);
    for (int d = 0; d < 4; d++) begin
      wr(IDX_WIDEN, 16'hfff3 | 16'(d << 2));
      rdr(IDX_WIDEN);
      chk(rd, 16'(d << 2));
      chk({14'h0, route.depth}, 16'(d));
    end
    wr(IDX_GP, 16'h0000);
    chk({14'h0, route.depth}, 16'h0000);
    wr(IDX_IRQ, 16'h1000);
    rdr(IDX_IRQ);
    chk(rd, 16'h1000);
    chk(16'(starts), 16'h0001);
    pulse(1'b0);
    wr(IDX_IRQ, 16'h0000);
    rdr(IDX_IRQ);
    chk(rd, 16'ha000);
    chk({15'h0, ctrl.rx[0]}, 16'h0000);
    wr(IDX_IRQ, 16'h8ff0);
    pulse(1'b1);
    pulse(1'b0);
    rdr(IDX_IRQ);
    chk(rd, 16'hc800);
    chk({15'h0, ctrl.rx[0]}, 16'h0001);
    wr(IDX_IRQ, 16'h8001);
    wr(IDX_IRQ, 16'h0002);
    rdr(IDX_IRQ);
    chk(rd, 16'h0001);
    wr(IDX_GP, 16'h8000);
    chk({9'h0, route}, 16'h0040);
    @(posedge clk_sys);
    cold_rst_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    cold_rst_n <= 1'b1;
    repeat (6) @(posedge bit_clk);
    chk({12'h0, window_page}, 16'h0001);
    chk({9'h0, route}, 16'h0000);
    wr(IDX_IRQ, 16'h0000);
    chk({12'h0, window_page}, 16'h0000);
    complete_run();
  end
endmodule : test_codec_gp_enhance_irq_paging_regs
